// >>> hdl/uart_status_rxbuf_extbit.sv
// Register side of a two-channel async serial unit: extension select,
// status flags and nine-bit receive buffer per channel.
// Assumes shifters, baud logic and the mode register sit outside, same clock.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "uart_status_cfg.svh"

module uart_status_rxbuf_extbit #(
    parameter int CHANNELS = 2
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire logic [31:0]                            addr,
    input  wire logic [15:0]                            wdata,
    input  wire logic                                   wr_en,
    input  wire logic                                   rd_en,
    output logic      [15:0]                            rdata,
    input  wire logic [CHANNELS-1:0][1:0]               parity_select,
    input  wire uart_status_pkg::char_len_t [CHANNELS-1:0] char_len,
    input  wire logic [CHANNELS-1:0]                    rx_enable,
    input  wire logic [CHANNELS-1:0]                    rx_busy,
    input  wire logic [CHANNELS-1:0]                    rx_done,
    input  wire uart_status_pkg::rx_frame_t [CHANNELS-1:0] rx_frame,
    input  wire logic [CHANNELS-1:0]                    tx_enable,
    input  wire logic [CHANNELS-1:0]                    tx_write,
    input  wire logic [CHANNELS-1:0]                    tx_last_bit,
    input  wire logic [CHANNELS-1:0]                    mode_write,
    output logic      [CHANNELS-1:0]                    expansion_bit_enable,
    output logic      [CHANNELS-1:0]                    tx_accept,
    output uart_status_pkg::irq_t [CHANNELS-1:0]        irq
);

    // ----------------------------------------
    // Address table
    // ----------------------------------------
    localparam logic [31:0] EXT_ADDR  [2] = '{`ADDR_EXT0,  `ADDR_EXT1};
    localparam logic [31:0] STS_ADDR  [2] = '{`ADDR_STS0,  `ADDR_STS1};
    localparam logic [31:0] BUFW_ADDR [2] = '{`ADDR_BUFW0, `ADDR_BUFW1};
    localparam logic [31:0] BUFL_ADDR [2] = '{`ADDR_BUFL0, `ADDR_BUFL1};

    // Only two address sets exist
    if (CHANNELS < 1 || CHANNELS > 2) begin : g_bad_channels
        $error("CHANNELS must be 1 or 2");
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [15:0] rd_chain [CHANNELS+1];
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;

    assign rd_chain[0] = `RDATA_RST;
    // Data stands only in the cycle after the strobe
    assign rdata_d     = rd_en ? rd_chain[CHANNELS] : `RDATA_RST;
    assign rdata       = rdata_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= `RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch

        // ----------------------------------------
        // Decode
        // ----------------------------------------
        logic        ext_hit;
        logic        sts_hit;
        logic        bufw_hit;
        logic        bufl_hit;
        logic        ext_wr;
        logic        buf_rd;

        assign ext_hit  = (addr == EXT_ADDR[i]);
        assign sts_hit  = (addr == STS_ADDR[i]);
        assign bufw_hit = (addr == BUFW_ADDR[i]);
        assign bufl_hit = (addr == BUFL_ADDR[i]);
        // Status and buffer ignore writes
        assign ext_wr   = wr_en & ext_hit;
        assign buf_rd   = rd_en & (bufw_hit | bufl_hit);

        // ----------------------------------------
        // Extension select
        // ----------------------------------------
        logic        ext_q;
        logic        ext_d;
        logic        nine_bit;
        logic        nine_q;

        assign ext_d    = ext_wr ? wdata[`EXT_EN_BIT] : ext_q;
        // Parity other than none overrides the select
        assign nine_bit = ext_q & (parity_select[i] == `PARITY_NONE);

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ext_q <= `EXT_RST;
            end else begin
                ext_q <= ext_d;
            end
        end

        // Registered copy for the outside shifters, one cycle late
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                nine_q <= `EXT_RST;
            end else begin
                nine_q <= nine_bit;
            end
        end

        assign expansion_bit_enable[i] = nine_q;

        // ----------------------------------------
        // Receive transfer
        // ----------------------------------------
        logic        take;
        logic [8:0]  mask9;
        logic [8:0]  mask8;
        logic [8:0]  mask7;
        logic [8:0]  masked;
        logic [8:0]  buf_q;
        logic [8:0]  buf_d;
        logic        unread_q;
        logic        unread_d;

        assign take   = rx_done[i] & rx_enable[i];
        assign mask9  = rx_frame[i].data;
        assign mask8  = {1'b0, rx_frame[i].data[`LOW_BYTE_MSB:0]};
        assign mask7  = {2'b00, rx_frame[i].data[`CHAR7_MSB:0]};
        // Current select, not the lagging copy, so a frame matches its mode
        assign masked = nine_bit ? mask9 :
                        (char_len[i] == uart_status_pkg::CHAR_8) ? mask8 : mask7;
        // New frame always lands, even over unread data
        assign buf_d    = take ? masked : buf_q;
        // A read in the same cycle took the old frame
        assign unread_d = take | (unread_q & ~buf_rd);

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                buf_q <= `BUF_RST;
            end else begin
                buf_q <= buf_d;
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                unread_q <= `FLAG_RST;
            end else begin
                unread_q <= unread_d;
            end
        end

        // ----------------------------------------
        // Error flags
        // ----------------------------------------
        // Set wins over the clearing read, so an error never slips by
        logic        flag_clr;
        logic        pe_set;
        logic        fe_set;
        logic        ov_set;
        logic        pe_q;
        logic        fe_q;
        logic        ov_q;
        logic        pe_d;
        logic        fe_d;
        logic        ov_d;

        assign pe_set = take & rx_frame[i].parity_err;
        assign fe_set = take & rx_frame[i].framing_err;
        assign ov_set = take & unread_q & ~buf_rd;
        assign flag_clr = buf_rd;
        assign pe_d     = pe_set | (pe_q & ~flag_clr);
        assign fe_d     = fe_set | (fe_q & ~flag_clr);
        assign ov_d     = ov_set | (ov_q & ~flag_clr);

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pe_q <= `FLAG_RST;
            end else begin
                pe_q <= pe_d;
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                fe_q <= `FLAG_RST;
            end else begin
                fe_q <= fe_d;
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ov_q <= `FLAG_RST;
            end else begin
                ov_q <= ov_d;
            end
        end

        // ----------------------------------------
        // Transmit state
        // ----------------------------------------
        uart_status_pkg::tx_state_t tx_q;
        uart_status_pkg::tx_state_t tx_d;
        logic        tx_busy;
        logic        tx_take;
        logic        tx_end;
        logic        tx_stop_last;
        logic        tx_stop_mode;

        assign tx_busy = (tx_q == uart_status_pkg::TX_BUSY);
        // Writes before completion are dropped
        assign tx_take = tx_write[i] & tx_enable[i] & ~tx_busy;
        assign tx_stop_last = tx_busy & tx_last_bit[i];
        // Mode rewrite aborts the frame but still reports completion
        assign tx_stop_mode = tx_busy & mode_write[i];
        assign tx_end       = tx_stop_last | tx_stop_mode;
        assign tx_accept[i] = tx_take;

        always_comb begin
            case (tx_q)
                uart_status_pkg::TX_IDLE: begin
                    tx_d = tx_take ? uart_status_pkg::TX_BUSY : uart_status_pkg::TX_IDLE;
                end
                uart_status_pkg::TX_BUSY: begin
                    tx_d = tx_end ? uart_status_pkg::TX_IDLE : uart_status_pkg::TX_BUSY;
                end
                default: begin
                    tx_d = uart_status_pkg::TX_IDLE;
                end
            endcase
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                tx_q <= uart_status_pkg::TX_IDLE;
            end else begin
                tx_q <= tx_d;
            end
        end

        // ----------------------------------------
        // Events, one-cycle pulses
        // ----------------------------------------
        uart_status_pkg::irq_t irq_d;
        logic        rx_mode_evt;
        logic        rx_any_err;
        logic        tx_evt_q;
        logic        rx_evt_q;
        logic        err_evt_q;

        // A rewrite in mid-reception still closes the frame for software
        assign rx_mode_evt           = mode_write[i] & rx_busy[i] & rx_enable[i];
        assign rx_any_err            = rx_frame[i].parity_err | rx_frame[i].framing_err | ov_set;
        assign irq_d.tx_complete_irq = tx_end;
        assign irq_d.rx_complete_irq = take | rx_mode_evt;
        assign irq_d.rx_error_irq    = take & rx_any_err;

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                tx_evt_q <= `FLAG_RST;
            end else begin
                tx_evt_q <= irq_d.tx_complete_irq;
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                rx_evt_q <= `FLAG_RST;
            end else begin
                rx_evt_q <= irq_d.rx_complete_irq;
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                err_evt_q <= `FLAG_RST;
            end else begin
                err_evt_q <= irq_d.rx_error_irq;
            end
        end

        assign irq[i].tx_complete_irq = tx_evt_q;
        assign irq[i].rx_complete_irq = rx_evt_q;
        assign irq[i].rx_error_irq    = err_evt_q;

        // ----------------------------------------
        // Register views
        // ----------------------------------------
        logic [7:0]  sts_tx;
        logic [7:0]  sts_pe;
        logic [7:0]  sts_fe;
        logic [7:0]  sts_ov;
        logic [7:0]  sts_val;
        logic [15:0] sts_view;
        logic [15:0] bufw_view;
        logic [15:0] bufl_view;
        logic [15:0] ext_view;
        logic [15:0] ch_rd;

        assign sts_tx    = {7'h00, tx_busy} << `STS_TX_BIT;
        assign sts_pe    = {7'h00, pe_q} << `STS_PE_BIT;
        assign sts_fe    = {7'h00, fe_q} << `STS_FE_BIT;
        assign sts_ov    = {7'h00, ov_q} << `STS_OV_BIT;
        // Bits 6 to 3 stay zero
        assign sts_val   = sts_tx | sts_pe | sts_fe | sts_ov;
        assign sts_view  = {8'h00, sts_val};
        assign bufw_view = {7'h00, buf_q};
        assign bufl_view = {8'h00, buf_q[`LOW_BYTE_MSB:0]};
        // Spare extension bits read zero
        assign ext_view  = {15'h0000, ext_q};
        assign ch_rd     = sts_hit  ? sts_view :
                           bufw_hit ? bufw_view :
                           bufl_hit ? bufl_view :
                           ext_hit  ? ext_view : `RDATA_RST;
        assign rd_chain[i+1] = rd_chain[i] | ch_rd;
    end

endmodule

// >>> hdl/uart_status_cfg.svh
// Constants for the serial status, receive buffer and extension bit block.
// Assumes a plain register port with byte addresses as printed for the device.
`ifndef UART_STATUS_CFG_SVH
`define UART_STATUS_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_EXT0      32'hfffff0c2
`define ADDR_STS0      32'hfffff0c4
`define ADDR_BUFW0     32'hfffff0c6
`define ADDR_BUFL0     32'hfffff0c8
`define ADDR_EXT1      32'hfffff0d2
`define ADDR_STS1      32'h0ffff0d4
`define ADDR_BUFW1     32'hfffff0d6
`define ADDR_BUFL1     32'hfffff0d8

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define EXT_EN_BIT     0
`define STS_TX_BIT     7
`define STS_PE_BIT     2
`define STS_FE_BIT     1
`define STS_OV_BIT     0
`define LOW_BYTE_MSB   7
`define CHAR7_MSB      6
`define PARITY_NONE    2'h0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EXT_RST        1'h0
`define FLAG_RST       1'h0
`define BUF_RST        9'h000
`define RDATA_RST      16'h0000

`endif

// >>> hdl/uart_status_pkg.sv
// Types shared by the serial status and receive buffer block.
// Assumes the constants header is included by the design file.
package uart_status_pkg;

    // ----------------------------------------
    // Frame from the receive shifter
    // ----------------------------------------
    typedef struct packed {
        logic [8:0] data;
        logic       parity_err;
        logic       framing_err;
    } rx_frame_t;

    // ----------------------------------------
    // Event pulses of one channel
    // ----------------------------------------
    typedef struct packed {
        logic tx_complete_irq;
        logic rx_complete_irq;
        logic rx_error_irq;
    } irq_t;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_BUSY = 1'b1
    } tx_state_t;

    typedef enum logic {
        CHAR_7 = 1'b0,
        CHAR_8 = 1'b1
    } char_len_t;

endpackage

// >>> test/uart_status_rxbuf_extbit_properties.sv
// Checker for the status, buffer and extension block ports.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ps
`include "uart_status_cfg.svh"
module uart_status_props #(parameter int CHANNELS = 2) (
    input wire logic                                  clk,
    input wire logic                                  rst_n,
    input wire logic [31:0]                           addr,
    input wire logic                                  rd_en,
    input wire logic [15:0]                           rdata,
    input wire logic [CHANNELS-1:0][1:0]              parity_select,
    input wire logic [CHANNELS-1:0]                   rx_enable,
    input wire logic [CHANNELS-1:0]                   rx_busy,
    input wire logic [CHANNELS-1:0]                   rx_done,
    input wire uart_status_pkg::rx_frame_t [CHANNELS-1:0] rx_frame,
    input wire logic [CHANNELS-1:0]                   tx_last_bit,
    input wire logic [CHANNELS-1:0]                   mode_write,
    input wire logic [CHANNELS-1:0]                   expansion_bit_enable,
    input wire logic [CHANNELS-1:0]                   tx_accept,
    input wire uart_status_pkg::irq_t [CHANNELS-1:0]  irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Transmit busy shadow, channel 0 only
    // ----------------------------------------
    logic busy_q;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) busy_q <= 1'b0;
        else busy_q <= tx_accept[0] | (busy_q & ~tx_last_bit[0] & ~mode_write[0]);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_rx_take_done: assert property (rx_done[0] && rx_enable[0] |=> irq[0].rx_complete_irq)
        else $error("rx completion missing");
    a_rx_err_or: assert property (rx_done[0] && rx_enable[0] && (rx_frame[0].parity_err ||
        rx_frame[0].framing_err) |=> irq[0].rx_error_irq) else $error("rx error event missing");
    a_rx_off_quiet: assert property (!rx_enable[0] |=> !irq[0].rx_complete_irq && !irq[0].rx_error_irq)
        else $error("rx event while disabled");
    a_mode_rx_done: assert property (mode_write[0] && rx_busy[0] && rx_enable[0] |=> irq[0].rx_complete_irq)
        else $error("mode rewrite gave no rx event");
    a_ext_gated: assert property (parity_select[0] != 2'h0 |=> !expansion_bit_enable[0])
        else $error("ninth bit with parity on");
    a_tx_last_irq: assert property (busy_q && tx_last_bit[0] |=> irq[0].tx_complete_irq ##1 !irq[0].tx_complete_irq)
        else $error("tx completion wrong");
    a_tx_busy_hold: assert property (busy_q |-> !tx_accept[0])
        else $error("write accepted while busy");
    a_sts_zero_bits: assert property (rd_en && addr == `ADDR_STS0 |=> rdata[15:8] == 8'h00 && rdata[6:3] == 4'h0)
        else $error("status spare bits set");
    a_low_view: assert property (rd_en && addr == `ADDR_BUFL0 |=> rdata[15:8] == 8'h00)
        else $error("low view upper byte set");
    a_word_view: assert property (rd_en && addr == `ADDR_BUFW0 |=> $stable(rdata[15:9]) && rdata[15:9] == 7'h00)
        else $error("word view upper bits set");
endmodule
bind uart_status_rxbuf_extbit uart_status_props #(.CHANNELS(CHANNELS)) i_props (.clk(clk), .rst_n(rst_n),
    .addr(addr), .rd_en(rd_en), .rdata(rdata), .parity_select(parity_select), .rx_enable(rx_enable),
    .rx_busy(rx_busy), .rx_done(rx_done), .rx_frame(rx_frame), .tx_last_bit(tx_last_bit),
    .mode_write(mode_write), .expansion_bit_enable(expansion_bit_enable), .tx_accept(tx_accept), .irq(irq));

// >>> test/remote_station_model.sv
// Far station: hands finished frames and last-bit pulses to the block.
// Assumes the bench calls one task at a time per channel.
`timescale 1ns/1ps
module remote_station_model (
    input  wire logic                        clk,
    output logic [1:0]                       rx_done,
    output uart_status_pkg::rx_frame_t [1:0] rx_frame,
    output logic [1:0]                       tx_last_bit
);
    initial begin
        rx_done = 2'h0;
        rx_frame = '0;
        tx_last_bit = 2'h0;
    end
    // Frame only valid in its pulse; inverted after so stale data never matches
    task automatic send(input int ch, input uart_status_pkg::rx_frame_t f);
        @(posedge clk);
        rx_done[ch] <= 1'b1;
        rx_frame[ch] <= f;
        @(posedge clk);
        rx_done[ch] <= 1'b0;
        rx_frame[ch] <= ~f;
    endtask
    task automatic end_tx(input int ch);
        @(posedge clk);
        tx_last_bit[ch] <= 1'b1;
        @(posedge clk);
        tx_last_bit[ch] <= 1'b0;
    endtask
endmodule

// >>> test/uart_status_rxbuf_extbit_tb.sv
// Bench for the status, buffer and extension block, random and corner cases.
// Assumes the far station model drives the receive and transmit pulses.
`timescale 1ns/1ps
`include "uart_status_cfg.svh"
module uart_status_rxbuf_extbit_tb;
    logic clk, rst_n, wr_en, rd_en, ch;
    logic [31:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [1:0][1:0] parity_select;
    uart_status_pkg::char_len_t [1:0] char_len;
    logic [1:0] rx_enable, rx_busy, rx_done, tx_enable, tx_write, tx_last_bit, mode_write, ext_en, tx_accept;
    uart_status_pkg::rx_frame_t [1:0] rx_frame;
    uart_status_pkg::irq_t [1:0] irq;
    uart_status_pkg::rx_frame_t f1, f2;
    logic [31:0] regs[5] = '{`ADDR_EXT0, `ADDR_STS0, `ADDR_EXT1, `ADDR_STS1, 32'h00000010};
    logic [31:0] sts[2] = '{`ADDR_STS0, `ADDR_STS1};
    int fails = 0, n_compared = 0, seed = 32'hfa7d3d30;
    uart_status_rxbuf_extbit #(.CHANNELS(2)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .parity_select(parity_select), .char_len(char_len),
        .rx_enable(rx_enable), .rx_busy(rx_busy), .rx_done(rx_done), .rx_frame(rx_frame), .tx_enable(tx_enable),
        .tx_write(tx_write), .tx_last_bit(tx_last_bit), .mode_write(mode_write), .expansion_bit_enable(ext_en),
        .tx_accept(tx_accept), .irq(irq));
    remote_station_model i_far (.clk(clk), .rx_done(rx_done), .rx_frame(rx_frame), .tx_last_bit(tx_last_bit));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] exp_buf(logic [8:0] d, logic nine, logic eight);
        return nine ? {7'h0, d} : eight ? {8'h0, d[7:0]} : {9'h0, d[6:0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read data lives one cycle only, so sample just after that edge
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict;
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {rst_n, wr_en, rd_en, addr, wdata, parity_select, rx_busy, tx_write, mode_write} = '0;
        char_len[0] = uart_status_pkg::CHAR_7;
        char_len[1] = uart_status_pkg::CHAR_7;
        rx_enable = 2'h3;
        tx_enable = 2'h3;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wr(`ADDR_STS0, 16'h00ff);
        foreach (regs[i]) begin
            rd(regs[i]);
            chk(v, 16'h0000, "reset");
        end
        $display("reset done");
        for (int i = 0; i < 8; i++) begin
            f1 = 11'($random(seed));
            parity_select[0] <= i[1:0];
            char_len[0] <= uart_status_pkg::char_len_t'(f1.framing_err);
            wr(`ADDR_EXT0, {15'h7fff, i[2]});
            rd(`ADDR_EXT0);
            chk(v, {15'h0, i[2]}, "ext");
            i_far.send(0, f1);
            #1 chk({14'h0, irq[0][1:0]}, {14'h0, 1'b1, f1.parity_err | f1.framing_err}, "rx_irq");
            rd(`ADDR_BUFW0);
            chk(v, exp_buf(f1.data, i[2] && i[1:0] == 0, f1.framing_err), "word");
            chk({15'h0, ext_en[0]}, {15'h0, i[2] && i[1:0] == 0}, "ext_en");
        end
        $display("mode test done");
        char_len[0] <= uart_status_pkg::CHAR_8;
        for (int i = 0; i < 4; i++) begin
            f1 = 11'($random(seed));
            f2 = 11'($random(seed));
            i_far.send(0, f1);
            i_far.send(0, f2);
            rd(`ADDR_STS0);
            chk(v, {13'h0, f1.parity_err | f2.parity_err, f1.framing_err | f2.framing_err, 1'b1}, "sts");
            rd(`ADDR_BUFL0);
            chk(v, {8'h0, f2.data[7:0]}, "low");
            rd(`ADDR_STS0);
            chk(v, 16'h0000, "cleared");
        end
        rx_enable[0] <= 1'b0;
        wr(`ADDR_BUFW0, 16'h0155);
        i_far.send(0, 11'($random(seed)));
        #1 chk({14'h0, irq[0][1:0]}, 16'h0000, "rx_off_irq");
        rd(`ADDR_BUFW0);
        chk(v, {8'h0, f2.data[7:0]}, "kept");
        rx_enable[0] <= 1'b1;
        f1 = 11'($random(seed));
        wr(`ADDR_EXT1, 16'h0001);
        rd(`ADDR_EXT1);
        chk(v, 16'h0001, "ext1");
        chk({15'h0, ext_en[1]}, 16'h0001, "ext_en1");
        i_far.send(1, f1);
        #1 chk({14'h0, irq[1][1:0]}, {14'h0, 1'b1, f1.parity_err | f1.framing_err}, "rx_irq1");
        rd(`ADDR_STS1);
        chk(v, {13'h0, f1.parity_err, f1.framing_err, 1'b0}, "sts1");
        rd(`ADDR_BUFL1);
        chk(v, {8'h0, f1.data[7:0]}, "low1");
        rd(`ADDR_BUFW1);
        chk(v, {7'h0, f1.data}, "word1");
        $display("error test done");
        for (int c = 0; c < 4; c++) begin
            ch = c[0];
            @(posedge clk);
            tx_write[ch] <= 1'b1;
            @(posedge clk);
            tx_write[ch] <= 1'b0;
            rd(sts[ch]);
            chk(v, 16'h0080, "busy");
            @(posedge clk);
            tx_write[ch] <= 1'b1;
            #1 chk({15'h0, tx_accept[ch]}, 16'h0000, "busy_refuse");
            @(posedge clk);
            tx_write[ch] <= 1'b0;
            if (c < 2) begin
                i_far.end_tx(ch);
            end else begin
                @(posedge clk);
                mode_write[ch] <= 1'b1;
                rx_busy[ch] <= 1'b1;
                @(posedge clk);
                mode_write[ch] <= 1'b0;
                rx_busy[ch] <= 1'b0;
            end
            #1 chk({15'h0, irq[ch].tx_complete_irq}, 16'h0001, "tx_irq");
            rd(sts[ch]);
            chk(v, 16'h0000, "idle");
        end
        tx_enable[1] <= 1'b0;
        @(posedge clk);
        tx_write[1] <= 1'b1;
        #1 chk({15'h0, tx_accept[1]}, 16'h0000, "tx_off");
        @(posedge clk);
        tx_write[1] <= 1'b0;
        rd(sts[1]);
        chk(v, 16'h0000, "tx_off_sts");
        $display("tx test done");
        give_verdict;
    end
endmodule
